// >>> common/vtpc_regs.vh
`ifndef VTPC_REGS_VH
`define VTPC_REGS_VH

// register indices; byte address on apb is four times the index
`define VTPC_IDX_MON_CTL 8'h63
`define VTPC_IDX_CTL 8'h64
`define VTPC_IDX_CFG 8'h65
`define VTPC_IDX_RED 8'h70
`define VTPC_IDX_GREEN 8'h71
`define VTPC_IDX_BLUE 8'h72
`define VTPC_IDX_FRAMES 8'h73
`define VTPC_IDX_STATUS 8'h74

// test_pattern_control fields
`define VTPC_CTL_SEL_HI 7
`define VTPC_CTL_SEL_LO 4
`define VTPC_CTL_COMPLY 3
`define VTPC_CTL_BARS 2
`define VTPC_CTL_REV 1
`define VTPC_CTL_EN 0
`define VTPC_CTL_RESET 8'h10

// config fields
`define VTPC_CFG_INV 1
`define VTPC_CFG_AUTO 0
`define VTPC_CFG_RESET 8'h00

// monitor output driver control field
`define VTPC_MON_PWDN 0
`define VTPC_MON_RESET 8'h00

// other reset values
`define VTPC_CUSTOM_RESET 8'h00
`define VTPC_FRAMES_RESET 8'h01

// internal pattern codes; 4'h1..4'he are the select codes themselves
`define VTPC_PAT_NONE 5'h00
`define VTPC_PAT_FIRST 5'h01
`define VTPC_PAT_SOLID_LAST 5'h05
`define VTPC_PAT_HRAMP_FIRST 5'h06
`define VTPC_PAT_HRAMP_LAST 5'h09
`define VTPC_PAT_VRAMP_FIRST 5'h0a
`define VTPC_PAT_VRAMP_LAST 5'h0d
`define VTPC_PAT_CUSTOM 5'h0e
`define VTPC_PAT_BARS 5'h10
`define VTPC_PAT_COMPLY 5'h11
`define VTPC_PAT_BANDS 5'h12

`endif

// >>> design/vtpc_pixel_colour.v
`timescale 1ns/1ns
`include "vtpc_regs.vh"

// turns a pattern code and pixel position into one registered pixel
module vtpc_pixel_colour (
    input wire ref_clk,
    input wire rst_n,
    input wire [4:0] pattern,
    input wire invert,
    input wire band_rev,
    input wire [7:0] h_level,
    input wire [7:0] v_level,
    input wire [2:0] bar_idx,
    input wire [1:0] band_idx,
    input wire comply_phase,
    input wire [23:0] custom_rgb,
    input wire [23:0] pass_rgb,
    output reg [23:0] pix_rgb
);
    reg [23:0] base; // colour before inversion
    reg [2:0] chan; // which of r, g, b are lit
    reg [7:0] level; // ramp level
    reg use_pass; // no pattern, video passes through
    reg [23:0] next_pix;

    // colour table: select, bars, bands, compliance
    always @* begin
        base = 24'h000000;
        chan = 3'b000;
        level = 8'h00;
        use_pass = 1'b0;
        case (pattern)
            5'h01: base = 24'hffffff;
            5'h02: base = 24'h000000;
            5'h03: base = 24'hff0000;
            5'h04: base = 24'h00ff00;
            5'h05: base = 24'h0000ff;
            5'h06, 5'h0a: chan = 3'b111;
            5'h07, 5'h0b: chan = 3'b100;
            5'h08, 5'h0c: chan = 3'b010;
            5'h09, 5'h0d: chan = 3'b001;
            `VTPC_PAT_CUSTOM: base = custom_rgb;
            `VTPC_PAT_BARS: begin
                // white yellow cyan green magenta red blue black
                case (bar_idx)
                    3'd0: chan = 3'b111;
                    3'd1: chan = 3'b110;
                    3'd2: chan = 3'b011;
                    3'd3: chan = 3'b010;
                    3'd4: chan = 3'b101;
                    3'd5: chan = 3'b100;
                    3'd6: chan = 3'b001;
                    default: chan = 3'b000;
                endcase
                level = 8'hff;
            end
            `VTPC_PAT_BANDS: begin
                // yellow cyan blue red, or blue cyan yellow red
                case (band_idx)
                    2'd0: chan = band_rev ? 3'b001 : 3'b110;
                    2'd1: chan = 3'b011;
                    2'd2: chan = band_rev ? 3'b110 : 3'b001;
                    default: chan = 3'b100;
                endcase
                level = 8'hff;
            end
            `VTPC_PAT_COMPLY: base = comply_phase ? 24'hffffff : 24'h000000;
            default: use_pass = 1'b1;
        endcase
        // ramps scale one level across the lit channels
        if (pattern >= `VTPC_PAT_HRAMP_FIRST && pattern <= `VTPC_PAT_HRAMP_LAST)
            level = h_level;
        else if (pattern >= `VTPC_PAT_VRAMP_FIRST && pattern <= `VTPC_PAT_VRAMP_LAST)
            level = v_level;
        if (chan != 3'b000)
            base = {chan[2] ? level : 8'h00, chan[1] ? level : 8'h00,
                    chan[0] ? level : 8'h00};
        if (use_pass)
            next_pix = pass_rgb;
        else if (invert)
            next_pix = ~base;
        else
            next_pix = base;
    end

    // pixel register; outputs black out of reset
    always @(posedge ref_clk) begin
        if (!rst_n)
            pix_rgb <= 24'h000000;
        else
            pix_rgb <= next_pix;
    end
endmodule // vtpc_pixel_colour

// >>> design/vtpc_top.v
`timescale 1ns/1ns
`include "vtpc_regs.vh"

module vtpc_top #(
    parameter ACTIVE_W = 2048, // active pixels per line
    parameter ACTIVE_H = 1080 // active lines per frame
) (
    input wire ref_clk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output wire pready,
    output reg [31:0] prdata,
    output reg pslverr,
    input wire in_de,
    input wire in_hsync,
    input wire in_vsync,
    input wire [23:0] in_rgb,
    output reg out_de,
    output reg out_hsync,
    output reg out_vsync,
    output wire [23:0] out_rgb,
    output wire monitor_output_powerdown
);
    // registers
    reg [7:0] test_pattern_control;
    reg [7:0] pattern_config; // invert and auto cycle
    reg [7:0] monitor_output_driver; // monitor driver power control
    reg [7:0] custom_red_level;
    reg [7:0] custom_green_level;
    reg [7:0] custom_blue_level;
    reg [7:0] frames_per_pattern; // frames shown before auto cycling moves
    reg ack; // setup seen, answer ready in access phase

    // video position state
    reg [11:0] x_cnt; // pixel within active line
    reg [11:0] y_cnt; // active line within frame
    reg de_q; // previous data enable
    reg vs_q; // previous vertical sync
    reg [7:0] frame_cnt; // frames shown of current cycled pattern
    reg [4:0] cycle_pat; // current auto cycled pattern
    reg [4:0] active_pat; // pattern chosen by priority, also read back as status

    // field views
    wire [3:0] fixed_pattern_select = test_pattern_control[`VTPC_CTL_SEL_HI:`VTPC_CTL_SEL_LO];
    wire compliance_pattern_enable = test_pattern_control[`VTPC_CTL_COMPLY];
    wire colour_bar_enable = test_pattern_control[`VTPC_CTL_BARS];
    wire band_order_reverse = test_pattern_control[`VTPC_CTL_REV];
    wire pattern_generator_enable = test_pattern_control[`VTPC_CTL_EN];
    wire colour_invert_enable = pattern_config[`VTPC_CFG_INV];
    wire auto_cycle_enable = pattern_config[`VTPC_CFG_AUTO];

    // bus decode
    wire [9:0] reg_idx = paddr[11:2]; // word index
    wire setup = psel & ~penable;
    wire wr_en = psel & penable & pready & pwrite;
    wire frame_start = in_vsync & ~vs_q; // rising sync edge starts a frame

    // zero wait states: the answer is prepared during the setup cycle
    assign pready = penable & ack;
    assign monitor_output_powerdown = monitor_output_driver[`VTPC_MON_PWDN];

    // read mux
    reg [7:0] rd_byte;
    reg rd_hit;
    always @* begin
        rd_hit = 1'b1;
        case (reg_idx)
            {2'b00, `VTPC_IDX_MON_CTL}: rd_byte = monitor_output_driver;
            {2'b00, `VTPC_IDX_CTL}: rd_byte = test_pattern_control;
            {2'b00, `VTPC_IDX_CFG}: rd_byte = pattern_config;
            {2'b00, `VTPC_IDX_RED}: rd_byte = custom_red_level;
            {2'b00, `VTPC_IDX_GREEN}: rd_byte = custom_green_level;
            {2'b00, `VTPC_IDX_BLUE}: rd_byte = custom_blue_level;
            {2'b00, `VTPC_IDX_FRAMES}: rd_byte = frames_per_pattern;
            {2'b00, `VTPC_IDX_STATUS}: rd_byte = {3'b000, active_pat};
            default: begin
                rd_byte = 8'h00;
                rd_hit = 1'b0; // unmapped answers with an error
            end
        endcase
    end

    // answer registers, loaded at the setup edge
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            ack <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            ack <= setup;
            if (setup) begin
                prdata <= pwrite ? 32'h00000000 : {24'h000000, rd_byte};
                pslverr <= ~rd_hit;
            end
        end
    end

    // register writes; only the low byte lane carries data
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            test_pattern_control <= `VTPC_CTL_RESET;
            pattern_config <= `VTPC_CFG_RESET;
            monitor_output_driver <= `VTPC_MON_RESET;
            custom_red_level <= `VTPC_CUSTOM_RESET;
            custom_green_level <= `VTPC_CUSTOM_RESET;
            custom_blue_level <= `VTPC_CUSTOM_RESET;
            frames_per_pattern <= `VTPC_FRAMES_RESET;
        end else if (wr_en && pstrb[0]) begin
            case (reg_idx)
                {2'b00, `VTPC_IDX_MON_CTL}: monitor_output_driver <= {7'h00, pwdata[0]};
                {2'b00, `VTPC_IDX_CTL}: test_pattern_control <= pwdata[7:0];
                {2'b00, `VTPC_IDX_CFG}: pattern_config <= {6'h00, pwdata[1:0]};
                {2'b00, `VTPC_IDX_RED}: custom_red_level <= pwdata[7:0];
                {2'b00, `VTPC_IDX_GREEN}: custom_green_level <= pwdata[7:0];
                {2'b00, `VTPC_IDX_BLUE}: custom_blue_level <= pwdata[7:0];
                {2'b00, `VTPC_IDX_FRAMES}: frames_per_pattern <= pwdata[7:0];
                default: ; // read-only or unmapped
            endcase
        end
    end

    // pixel and line counters from the incoming timing
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            x_cnt <= 12'h000;
            y_cnt <= 12'h000;
            de_q <= 1'b0;
            vs_q <= 1'b0;
        end else begin
            de_q <= in_de;
            vs_q <= in_vsync;
            if (in_de)
                x_cnt <= x_cnt + 12'h001;
            else
                x_cnt <= 12'h000;
            if (frame_start)
                y_cnt <= 12'h000;
            else if (de_q && !in_de)
                y_cnt <= y_cnt + 12'h001; // line ended
        end
    end

    // auto cycling: select codes, then bars, then bands, then wrap
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            frame_cnt <= 8'h00;
            cycle_pat <= `VTPC_PAT_FIRST;
        end else if (!auto_cycle_enable) begin
            frame_cnt <= 8'h00;
            cycle_pat <= {1'b0, fixed_pattern_select}; // resume from the fixed choice
        end else if (frame_start) begin
            if (frame_cnt + 8'h01 >= frames_per_pattern) begin
                frame_cnt <= 8'h00;
                case (cycle_pat)
                    `VTPC_PAT_CUSTOM: cycle_pat <= `VTPC_PAT_BARS;
                    `VTPC_PAT_BARS: cycle_pat <= `VTPC_PAT_BANDS;
                    `VTPC_PAT_BANDS: cycle_pat <= `VTPC_PAT_FIRST;
                    default: begin
                        if (cycle_pat < `VTPC_PAT_CUSTOM && cycle_pat != `VTPC_PAT_NONE)
                            cycle_pat <= cycle_pat + 5'h01;
                        else
                            cycle_pat <= `VTPC_PAT_FIRST; // skip reserved codes
                    end
                endcase
            end else begin
                frame_cnt <= frame_cnt + 8'h01;
            end
        end
    end

    // pattern priority
    always @* begin
        if (!pattern_generator_enable)
            active_pat = `VTPC_PAT_NONE;
        else if (compliance_pattern_enable)
            active_pat = `VTPC_PAT_COMPLY;
        else if (colour_bar_enable)
            active_pat = `VTPC_PAT_BARS;
        else if (auto_cycle_enable)
            active_pat = cycle_pat;
        else if (fixed_pattern_select == 4'hf)
            active_pat = `VTPC_PAT_NONE;
        else
            active_pat = {1'b0, fixed_pattern_select};
    end

    // even spreading: constant divide by the active size
    wire [19:0] h_prod = {x_cnt, 8'h00};
    wire [19:0] v_prod = {y_cnt, 8'h00};
    // quotients keep the full parameter width; the clamps below cut them on purpose
    wire [31:0] h_div = h_prod / ACTIVE_W;
    wire [31:0] v_div = v_prod / ACTIVE_H;
    wire [14:0] bar_prod = {x_cnt, 3'b000};
    wire [31:0] bar_div = bar_prod / ACTIVE_W;
    wire [13:0] band_prod = {x_cnt, 2'b00};
    wire [31:0] band_div = band_prod / ACTIVE_W;
    // limitation: positions past the active size clamp to the last step
    wire [7:0] h_level = (h_div > 32'd255) ? 8'hff : h_div[7:0];
    wire [7:0] v_level = (v_div > 32'd255) ? 8'hff : v_div[7:0];
    wire [2:0] bar_idx = (bar_div > 32'd7) ? 3'd7 : bar_div[2:0];
    wire [1:0] band_idx = (band_div > 32'd3) ? 2'd3 : band_div[1:0];
    // compliance pattern: checkerboard of single pixels
    wire comply_phase = x_cnt[0] ^ y_cnt[0];

    // colour generation, one cycle of latency
    vtpc_pixel_colour u_colour (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pattern(active_pat),
        .invert(colour_invert_enable),
        .band_rev(band_order_reverse),
        .h_level(h_level),
        .v_level(v_level),
        .bar_idx(bar_idx),
        .band_idx(band_idx),
        .comply_phase(comply_phase),
        .custom_rgb({custom_red_level, custom_green_level, custom_blue_level}),
        .pass_rgb(in_rgb),
        .pix_rgb(out_rgb)
    );

    // timing delayed to line up with the pixel register
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            out_de <= 1'b0;
            out_hsync <= 1'b0;
            out_vsync <= 1'b0;
        end else begin
            out_de <= in_de;
            out_hsync <= in_hsync;
            out_vsync <= in_vsync;
        end
    end
endmodule // vtpc_top

// >>> sim/vtpc_chk.sv
`timescale 1ns/1ns
`include "vtpc_regs.vh"

// port-level watch on register access and video delay
module vtpc_chk (
    input wire ref_clk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    input wire pready,
    input wire [31:0] prdata,
    input wire pslverr,
    input wire in_de,
    input wire in_hsync,
    input wire in_vsync,
    input wire [23:0] in_rgb,
    input wire out_de,
    input wire out_hsync,
    input wire out_vsync,
    input wire [23:0] out_rgb,
    input wire monitor_output_powerdown
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire acc = psel && penable && pready; // transfer completes here
    wire [9:0] idx = paddr[11:2];
    wire mapped = idx == 10'h63 || idx == 10'h64 || idx == 10'h65
        || (idx >= 10'h70 && idx <= 10'h74);
    reg [7:0] ctl; // shadow of the control register
    reg mon; // shadow of the driver powerdown bit
    // shadows follow completed, strobed writes only
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            ctl <= `VTPC_CTL_RESET;
            mon <= 1'b0;
        end else if (acc && pwrite && pstrb[0]) begin
            if (idx == `VTPC_IDX_CTL) ctl <= pwdata[7:0];
            if (idx == `VTPC_IDX_MON_CTL) mon <= pwdata[0];
        end
    end
    a_zero_wait: assert property (psel && !penable ##1 psel && penable |-> pready)
        else $error("no ready in first access cycle");
    a_ready_idle: assert property (!penable |-> !pready)
        else $error("ready outside access");
    a_ctl_readback: assert property (acc && !pwrite && idx == `VTPC_IDX_CTL
        |-> prdata == {24'h0, ctl})
        else $error("control readback wrong");
    a_unmapped_err: assert property (acc && !mapped |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (acc && mapped |-> !pslverr)
        else $error("mapped access refused");
    a_mon_follow: assert property ($past(rst_n) |-> monitor_output_powerdown == mon)
        else $error("powerdown level wrong");
    a_de_delay: assert property ($past(rst_n) |-> out_de == $past(in_de))
        else $error("enable not delayed one cycle");
    a_sync_delay: assert property ($past(rst_n) |-> out_hsync == $past(in_hsync)
        && out_vsync == $past(in_vsync))
        else $error("sync not delayed one cycle");
    a_pass_off: assert property ($past(rst_n) && $past(rst_n, 2) && !$past(ctl[0])
        && !$past(ctl[0], 2) |-> out_rgb == $past(in_rgb))
        else $error("disabled generator altered video");
endmodule // vtpc_chk

bind vtpc_top vtpc_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .in_de(in_de), .in_rgb(in_rgb),
    .in_hsync(in_hsync), .in_vsync(in_vsync), .out_hsync(out_hsync), .out_vsync(out_vsync),
    .out_de(out_de), .out_rgb(out_rgb), .monitor_output_powerdown(monitor_output_powerdown));

// >>> sim/vtpc_display_model.sv
`timescale 1ns/1ns

// raster source plus display capture of the generated frame
module vtpc_display_model #(
    parameter W = 16, // active pixels per line
    parameter H = 8 // active lines
) (
    input wire ref_clk,
    output logic in_de,
    output logic in_hsync,
    output logic in_vsync,
    output logic [23:0] in_rgb,
    input wire out_de,
    input wire out_vsync,
    input wire [23:0] out_rgb,
    output int frames
);
    localparam LT = W + 4; // line with blanking
    int pos = 0; // place in the raster
    int ox = 0;
    int oy = 0;
    logic vs_d = 1'b0;
    logic [23:0] pix [0:H-1][0:W-1]; // last captured frame
    int frame_count = 0; // frame starts seen at the display, one driver only
    assign frames = frame_count;
    // row 0 holds only the frame sync and a line sync, no active pixels, so no line is lost
    always @(posedge ref_clk) begin
        pos <= (pos + 1) % (LT * (H + 1));
        in_vsync <= pos / LT == 0 && pos % LT < 2;
        in_hsync <= pos % LT == W + 1;
        in_de <= pos / LT > 0 && pos % LT < W;
        in_rgb <= {8'h5a, 8'(pos / LT), 8'(pos % LT)};
    end
    // capture keyed on delayed timing, as a panel would
    always @(posedge ref_clk) begin
        vs_d <= out_vsync;
        if (out_vsync && !vs_d) begin
            oy <= 0;
            frame_count <= frame_count + 1;
        end
        if (out_de) begin
            if (ox < W && oy < H) pix[oy][ox] <= out_rgb;
            ox <= ox + 1;
        end else if (ox != 0) begin
            ox <= 0;
            oy <= oy + 1;
        end
    end
endmodule // vtpc_display_model

// >>> sim/video_test_pattern_control_test.sv
`timescale 1ns/1ns
`include "vtpc_regs.vh"

// register and pattern checks over apb and captured frames
module video_test_pattern_control_test;
    localparam W = 16;
    localparam H = 8;
    localparam logic [23:0] bars_rgb [8] = '{24'hffffff, 24'hffff00, 24'h00ffff, 24'h00ff00,
        24'hff00ff, 24'hff0000, 24'h0000ff, 24'h000000};
    localparam logic [23:0] band_fw [4] = '{24'hffff00, 24'h00ffff, 24'h0000ff, 24'hff0000};
    localparam logic [23:0] band_rv [4] = '{24'h0000ff, 24'h00ffff, 24'hffff00, 24'hff0000};
    localparam logic [7:0] ctls [17] = '{8'h10, 8'h11, 8'h21, 8'h51, 8'h61, 8'h71, 8'h81,
        8'h91, 8'ha1, 8'hb1, 8'hc1, 8'hd1, 8'he1, 8'h01, 8'hf1, 8'h65, 8'h6d};
    logic ref_clk, rst_n, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
    wire pready, pslverr, in_de, in_hsync, in_vsync, out_de, out_hsync, out_vsync;
    wire monitor_output_powerdown;
    wire [31:0] prdata;
    wire [23:0] in_rgb, out_rgb;
    int frames, err_total = 0, compares = 0;
    vtpc_top #(.ACTIVE_W(W), .ACTIVE_H(H)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr), .in_de(in_de),
        .in_hsync(in_hsync), .in_vsync(in_vsync), .in_rgb(in_rgb), .out_de(out_de),
        .out_hsync(out_hsync), .out_vsync(out_vsync), .out_rgb(out_rgb),
        .monitor_output_powerdown(monitor_output_powerdown));
    vtpc_display_model #(.W(W), .H(H)) u_disp (.ref_clk(ref_clk), .in_de(in_de),
        .in_hsync(in_hsync), .in_vsync(in_vsync), .in_rgb(in_rgb), .out_de(out_de),
        .out_vsync(out_vsync), .out_rgb(out_rgb), .frames(frames));
    task automatic final_report();
        if (err_total == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t reg got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_pix(input logic [23:0] got, input logic [23:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t pixel got %h exp %h", $time, got, exp);
        end
    endtask
    // one apb transfer; request held until ready is sampled
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge ref_clk);
        penable <= 1'b1;
        // only the watchdog ends a wait that never sees ready
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, idx, d, r, e);
    endtask
    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp, input logic ee);
        logic [31:0] r;
        logic e;
        apb(1'b0, idx, 8'h0, r, e);
        chk_reg(r, {24'h0, exp});
        chk_reg(32'(e), 32'(ee));
    endtask
    task automatic status(output logic [31:0] s);
        logic [31:0] r;
        logic e;
        apb(1'b0, `VTPC_IDX_STATUS, 8'h0, r, e);
        s = r;
    endtask
    task automatic wait_frames(input int n);
        int f;
        f = frames;
        while (frames < f + n) @(posedge ref_clk);
    endtask
    function automatic logic [23:0] exp_pix(input int c, input int inv, input logic rev,
                                            input int x, input int y);
        logic [7:0] l;
        logic [23:0] p;
        l = 8'(c < 10 ? x * 256 / W : y * 256 / H);
        case (c)
            1: p = 24'hffffff;
            2: p = 24'h000000;
            3: p = 24'hff0000;
            4: p = 24'h00ff00;
            5: p = 24'h0000ff;
            6, 10: p = {l, l, l};
            7, 11: p = {l, 16'h0};
            8, 12: p = {8'h0, l, 8'h0};
            9, 13: p = {16'h0, l};
            14: p = 24'h123456;
            16: p = bars_rgb[x * 8 / W];
            18: p = rev ? band_rv[x * 4 / W] : band_fw[x * 4 / W];
            default: return {8'h5a, 8'(y + 1), 8'(x)};
        endcase
        return inv != 0 ? ~p : p;
    endfunction
    // two opposite corners and eight points spread across the captured frame
    task automatic pix_set(input int s, input int inv, input logic rev);
        foreach (bars_rgb[i]) begin
            chk_pix(u_disp.pix[i % 3 * 3 + 1][i * 2 + 1],
                    exp_pix(s, inv, rev, i * 2 + 1, i % 3 * 3 + 1));
        end
        chk_pix(u_disp.pix[H-1][W-1], exp_pix(s, inv, rev, W - 1, H - 1));
        chk_pix(u_disp.pix[0][0], exp_pix(s, inv, rev, 0, 0));
    endtask
    task automatic frame_chk(input logic [7:0] c, input int inv);
        int s;
        logic [31:0] got;
        wr(`VTPC_IDX_CTL, c);
        wait_frames(2);
        s = !c[0] ? 0 : c[3] ? 17 : c[2] ? 16 : (c[7:4] == 0 || c[7:4] == 15) ? 0 : c[7:4];
        if (s == 17) begin
            chk_pix(u_disp.pix[0][0] ^ u_disp.pix[0][1], 24'hffffff);
            chk_pix(u_disp.pix[0][0] ^ u_disp.pix[1][1], 24'h000000);
        end else
            pix_set(s, inv, c[1]);
        status(got);
        chk_reg(32'(got), 32'(s));
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // hang guard, well beyond the expected run
    initial begin
        #(20 * 60000);
        err_total++;
        final_report();
    end
    initial begin
        logic [31:0] st;
        logic [31:0] v;
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        pstrb = 4'hf;
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd_chk(`VTPC_IDX_CTL, 8'h10, 1'b0);
        rd_chk(8'h40, 8'h00, 1'b1);
        rd_chk(`VTPC_IDX_CFG, 8'h00, 1'b0);
        rd_chk(`VTPC_IDX_FRAMES, 8'h01, 1'b0);
        wr(`VTPC_IDX_MON_CTL, 8'h01);
        rd_chk(`VTPC_IDX_MON_CTL, 8'h01, 1'b0);
        chk_reg(32'(monitor_output_powerdown), 32'h1);
        // a write without the low byte strobe must leave the register alone
        pstrb <= 4'he;
        wr(`VTPC_IDX_MON_CTL, 8'h00);
        pstrb <= 4'hf;
        rd_chk(`VTPC_IDX_MON_CTL, 8'h01, 1'b0);
        wr(`VTPC_IDX_RED, 8'h12);
        wr(`VTPC_IDX_GREEN, 8'h34);
        wr(`VTPC_IDX_BLUE, 8'h56);
        for (int inv = 0; inv < 2; inv++) begin
            wr(`VTPC_IDX_CFG, 8'(inv * 2));
            foreach (ctls[i]) frame_chk(ctls[i], inv);
        end
        // select field set to 3 must be ignored while cycling; both band orders
        for (int r = 1; r >= 0; r--) begin
            wr(`VTPC_IDX_CTL, r != 0 ? 8'h33 : 8'h31);
            if (r != 0) wr(`VTPC_IDX_CFG, 8'h01);
            wait_frames(1);
            status(st);
            repeat (17) begin
                wait_frames(1);
                pix_set(st, 0, 1'(r));
                status(v);
                st = st == 14 ? 16 : st == 16 ? 18 : st == 18 ? 1 : st + 1;
                chk_reg(32'(v), 32'(st));
            end
        end
        final_report();
    end
endmodule // video_test_pattern_control_test
